/* File: rtl/sac_consts.vh */
// Register offsets, field positions, reset values and timing counts
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH
`define SAC_OFS_CONTROL 5'h00
`define SAC_OFS_STATUS_CONTROL 5'h04
`define SAC_OFS_RESULT 5'h08
`define SAC_OFS_IRQ_STATUS 5'h0C
`define SAC_OFS_IRQ_MASK 5'h10
`define SAC_OFS_CHANNEL_SELECT 5'h14
`define SAC_ADDR_W 5
`define SAC_BIT_POWER_UP 7
`define SAC_BIT_JUSTIFY 6
`define SAC_BIT_EIGHT_BIT_RESOLUTION_SELECT 5
`define SAC_BIT_SIGNED 4
`define SAC_CONTROL_RESET 8'h00
`define SAC_SC_CONTINUOUS 5
`define SAC_SC_INT_EN 6
`define SAC_SC_CHAN_MSB 4
`define SAC_CONV_PERIODS 5'd28
`define SAC_CONV_TIME_NS 14000
`define SAC_CONV_CLK_KHZ 2000
`define SAC_RESP_OKAY 2'h0
`define SAC_RESP_SLVERR 2'h2
`endif

/* File: rtl/sac_control.v */
// Converter control: bus slave, prescaler, sequencer, result formatting
//
// What this block does
// - Stop mode aborts conversion, powers analog off
// - Leaving stop starts nothing, registers kept
// - Power-up bit restores operation after stop
// - Power-up clear gates clock, aborts conversion
// - Registers accessible while powered down
// - Power-up bit resets to zero
// - Control write aborts, starts nothing new
// - Left justify maps result high bits
// - Right justify maps bits nine eight low
// - Eight-bit mode uses high byte only
// - Signed mode inverts result MSB
// - Signed ignored when right justified
// - Signed ranges are two's complement spans
// - Prescale field sets clock division
// - Division is two times (prescale plus one)
// - Conversion takes twenty-eight conversion clocks
// - Each channel pin selectable analog or port
// - Status write clears flag, starts conversion
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "sac_consts.vh"
// Register map, one 32-bit word each, data in the low bits:
//   0x00 control: power up, justify right, eight bit, signed, prescale
//   0x04 status and control: complete flag (read only), interrupt
//        enable, continuous, channel
//   0x08 result: high byte in 15:8, low byte in 7:0 (read only)
//   0x0C interrupt status, bit 0, write one to clear
//   0x10 interrupt mask, bit 0
//   0x14 analog pin enable, one bit per channel pin
// Only byte lane 0 writes; other offsets answer SLVERR.

module sac_control (
   input wire CLK,
   input wire RST_N,
   input wire STOP_MODE,
   input wire [9:0] CORE_RESULT,
   input wire CORE_DONE,
   output reg CORE_SAMPLE,
   output reg CORE_CONV_CLK,
   output wire ANALOG_ON,
   output wire [2:0] CHANNEL,
   output reg [7:0] ANALOG_PIN_ENABLE,
   output wire IRQ,
   input wire [`SAC_ADDR_W-1:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output wire S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output wire S_AXI_WREADY,
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [`SAC_ADDR_W-1:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output wire S_AXI_ARREADY,
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY
);
   localparam ST_IDLE = 1'b0;
   localparam ST_CONV = 1'b1;

   // Software visible registers
   reg [7:0] control;
   reg [6:0] status_control;
   reg [7:0] result_high_byte;
   reg [7:0] result_low_byte;
   reg conversion_complete_flag;
   reg irq_status;
   reg irq_mask;
   // Sequencer and prescaler state
   reg state;
   reg [4:0] presc_cnt;
   reg [4:0] period_cnt;
   // Write channel items held until their partner arrives
   reg aw_held;
   reg w_held;
   reg [`SAC_ADDR_W-1:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   // Combinational results
   reg [7:0] next_high;
   reg [7:0] next_low;
   reg [31:0] rd_word;
   reg rd_ok;
   reg wr_known;

   // Control register fields
   wire converter_power_up = control[`SAC_BIT_POWER_UP];
   wire justify_right_select = control[`SAC_BIT_JUSTIFY];
   wire eight_bit_resolution_select = control[`SAC_BIT_EIGHT_BIT_RESOLUTION_SELECT];
   wire signed_result_select = control[`SAC_BIT_SIGNED];
   wire [3:0] prescale_rate_select = control[3:0];
   // Stop mode overrides power up; registers are never touched by it
   wire running = converter_power_up & ~STOP_MODE;
   // Ticks once per conversion clock half period
   wire presc_tick = presc_cnt == {1'b0, prescale_rate_select};
   wire conv_edge = presc_tick & CORE_CONV_CLK;

   // Write path: address and data taken independently, one at a time.
   // Each ready drops once its item is held and stays low until the
   // response has been accepted, so only one write is ever in flight.
   assign S_AXI_AWREADY = ~aw_held & ~S_AXI_BVALID;
   assign S_AXI_WREADY = ~w_held & ~S_AXI_BVALID;
   wire [`SAC_ADDR_W-1:0] wa = S_AXI_AWVALID & S_AXI_AWREADY ?
      S_AXI_AWADDR : aw_addr;
   wire [31:0] wd = S_AXI_WVALID & S_AXI_WREADY ? S_AXI_WDATA : w_data;
   wire [3:0] ws = S_AXI_WVALID & S_AXI_WREADY ? S_AXI_WSTRB : w_strb;
   wire have_aw = aw_held | (S_AXI_AWVALID & S_AXI_AWREADY);
   wire have_w = w_held | (S_AXI_WVALID & S_AXI_WREADY);
   // A write fires once address and data are both present
   wire wr_fire = have_aw & have_w;
   wire wr_lane0 = wr_fire & ws[0];
   // Registers stay writable in power down and in stop mode
   wire wr_ctl = wr_lane0 & (wa == `SAC_OFS_CONTROL);
   wire wr_sc = wr_lane0 & (wa == `SAC_OFS_STATUS_CONTROL);
   wire wr_ist = wr_lane0 & (wa == `SAC_OFS_IRQ_STATUS);
   wire wr_msk = wr_lane0 & (wa == `SAC_OFS_IRQ_MASK);
   wire wr_pin = wr_lane0 & (wa == `SAC_OFS_CHANNEL_SELECT);
   // Only mapped offsets answer OKAY; the rest take SLVERR and are dropped
   always @* begin
      case (wa)
         `SAC_OFS_CONTROL: wr_known = 1'b1;
         `SAC_OFS_STATUS_CONTROL: wr_known = 1'b1;
         `SAC_OFS_RESULT: wr_known = 1'b1;
         `SAC_OFS_IRQ_STATUS: wr_known = 1'b1;
         `SAC_OFS_IRQ_MASK: wr_known = 1'b1;
         `SAC_OFS_CHANNEL_SELECT: wr_known = 1'b1;
         default: wr_known = 1'b0;
      endcase
   end
   // Last falling conversion clock edge of the period count
   wire finish = (state == ST_CONV) & conv_edge &
      (period_cnt == `SAC_CONV_PERIODS - 5'd1);
   // Control write or power loss cancels; status write restarts
   wire abort = wr_ctl | ~running;

   // Read ready, analog enable, channel and interrupt outputs
   assign S_AXI_ARREADY = ~S_AXI_RVALID;
   assign ANALOG_ON = running & (state == ST_CONV);
   assign CHANNEL = status_control[2:0];
   assign IRQ = irq_status & irq_mask;

   // Bus write handshake and register writes. Every register takes lane
   // 0 only; a write to a read-only or unmapped word changes nothing,
   // and registers stay reachable in power down and stop mode alike.
   always @(posedge CLK) begin
      if (!RST_N) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= {`SAC_ADDR_W{1'b0}};
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `SAC_RESP_OKAY;
         control <= `SAC_CONTROL_RESET;
         status_control <= 7'h00;
         irq_mask <= 1'b0;
         ANALOG_PIN_ENABLE <= 8'h00;
      end else begin
         // Capture each item on its own handshake
         if (S_AXI_AWVALID & S_AXI_AWREADY) begin
            aw_addr <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID & S_AXI_WREADY) begin
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
         // Response once both halves are in hand
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_known ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
         end else begin
            aw_held <= have_aw;
            w_held <= have_w;
            if (S_AXI_BREADY) begin
               S_AXI_BVALID <= 1'b0;
            end
         end
         // Register updates; the control write also aborts a conversion
         if (wr_ctl) begin
            control <= wd[7:0];
         end
         if (wr_sc) begin
            status_control <= wd[6:0];
         end
         if (wr_msk) begin
            irq_mask <= wd[0];
         end
         if (wr_pin) begin
            ANALOG_PIN_ENABLE <= wd[7:0];
         end
      end
   end

   // Prescaler: bus clock divided by 2*(field+1). The clock is held low
   // outside a conversion as well as in power down, which saves power
   // and lets every conversion start from a known low phase.
   always @(posedge CLK) begin
      if (!RST_N || !running || state != ST_CONV) begin
         presc_cnt <= 5'd0;
         CORE_CONV_CLK <= 1'b0;
      end else if (presc_tick) begin
         // Half period reached: flip the conversion clock
         presc_cnt <= 5'd0;
         CORE_CONV_CLK <= ~CORE_CONV_CLK;
      end else begin
         presc_cnt <= presc_cnt + 5'd1;
      end
   end

   // Result formatting by resolution, justification and sign. Eight-bit
   // mode always sits left justified in the high byte, so the justify
   // bit only gates the sign there; the sign applies only while justify is clear.
   always @* begin
      // Left justified by default: bits 9..2 high, bits 1..0 on top of low
      next_high = CORE_RESULT[9:2];
      next_low = {CORE_RESULT[1:0], 6'h00};
      if (eight_bit_resolution_select) begin
         // Eight bits only; the low byte reads zero
         next_low = 8'h00;
         if (signed_result_select & ~justify_right_select) begin
            next_high[7] = ~CORE_RESULT[9];
         end
      end else if (justify_right_select) begin
         // Right justified ten bits, always unsigned
         next_high = {6'h00, CORE_RESULT[9:8]};
         next_low = CORE_RESULT[7:0];
      end else if (signed_result_select) begin
         // Two's complement by flipping the top result bit
         next_high[7] = ~CORE_RESULT[9];
      end
   end

   // Sequencer: a period count of 28 conversion clocks per result.
   // Abort, from a control write or power loss, wins over a status write
   // in the same cycle; leaving stop mode never restarts on its own.
   always @(posedge CLK) begin
      if (!RST_N) begin
         state <= ST_IDLE;
         period_cnt <= 5'd0;
         CORE_SAMPLE <= 1'b0;
         result_high_byte <= 8'h00;
         result_low_byte <= 8'h00;
         conversion_complete_flag <= 1'b0;
      end else begin
         // Sample strobe is a single cycle pulse
         CORE_SAMPLE <= 1'b0;
         if (abort) begin
            state <= ST_IDLE;
            period_cnt <= 5'd0;
            // A status write still clears the flag while nothing may run
            if (wr_sc) begin
               conversion_complete_flag <= 1'b0;
            end
         end else if (wr_sc) begin
            state <= ST_CONV;
            period_cnt <= 5'd0;
            CORE_SAMPLE <= 1'b1;
            conversion_complete_flag <= 1'b0;
         end else if (finish) begin
            // Result bytes and flag land on the same edge
            result_high_byte <= next_high;
            result_low_byte <= next_low;
            conversion_complete_flag <= 1'b1;
            period_cnt <= 5'd0;
            // Continuous mode restarts at once, single mode idles
            if (status_control[`SAC_SC_CONTINUOUS]) begin
               CORE_SAMPLE <= 1'b1;
            end else begin
               state <= ST_IDLE;
            end
         end else if (state == ST_CONV && conv_edge) begin
            period_cnt <= period_cnt + 5'd1;
         end
      end
   end

   // Sticky interrupt: set beats a write-one clear so no completion is
   // lost. A status write cancels a pending request and drops a finish
   // in the same cycle, because that write restarts the conversion.
   always @(posedge CLK) begin
      if (!RST_N) begin
         irq_status <= 1'b0;
      end else if (finish & ~abort & ~wr_sc &
         status_control[`SAC_SC_INT_EN]) begin
         irq_status <= 1'b1;
      end else if ((wr_ist & wd[0]) | wr_sc) begin
         irq_status <= 1'b0;
      end
   end

   // Read data mux; unused upper bits read zero, unmapped offsets SLVERR
   always @* begin
      rd_word = 32'h00000000;
      rd_ok = 1'b1;
      case (S_AXI_ARADDR)
         `SAC_OFS_CONTROL: begin
            rd_word[7:0] = control;
         end
         `SAC_OFS_STATUS_CONTROL: begin
            rd_word[7:0] = {conversion_complete_flag, status_control};
         end
         `SAC_OFS_RESULT: begin
            rd_word[15:0] = {result_high_byte, result_low_byte};
         end
         `SAC_OFS_IRQ_STATUS: begin
            rd_word[0] = irq_status;
         end
         `SAC_OFS_IRQ_MASK: begin
            rd_word[0] = irq_mask;
         end
         `SAC_OFS_CHANNEL_SELECT: begin
            rd_word[7:0] = ANALOG_PIN_ENABLE;
         end
         default: begin
            rd_ok = 1'b0;
         end
      endcase
   end

   // Read channel: answer one cycle after address is taken; the word is
   // captured at that edge so later register changes cannot tear it
   always @(posedge CLK) begin
      if (!RST_N) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h00000000;
         S_AXI_RRESP <= `SAC_RESP_OKAY;
      end else if (S_AXI_ARVALID & S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= rd_word;
         S_AXI_RRESP <= rd_ok ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
         // Data held until the master takes it
         S_AXI_RVALID <= 1'b0;
      end
   end
endmodule

/* File: verification/sac_control_properties.sv */
// Port-level checks for the converter control block
`timescale 1ns/1ps
module sac_chk (
   input wire CLK,
   input wire RST_N,
   input wire STOP_MODE,
   input wire CORE_SAMPLE,
   input wire CORE_CONV_CLK,
   input wire ANALOG_ON,
   input wire [4:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   input wire S_AXI_AWREADY,
   input wire S_AXI_WVALID
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // Handshakes are taken together while the slave is idle
   wire wr_take = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID;
   property p_stop; STOP_MODE |=> !ANALOG_ON; endproperty
   a_stop: assert property (p_stop) else $error("analog on in stop");
   property p_wake; $fell(STOP_MODE) |-> !CORE_SAMPLE [*2]; endproperty
   a_wake: assert property (p_wake) else $error("start after stop");
   property p_gate; !ANALOG_ON [*2] |-> !CORE_CONV_CLK; endproperty
   a_gate: assert property (p_gate) else $error("clock not gated");
   property p_rst; $rose(RST_N) |-> !ANALOG_ON && !CORE_CONV_CLK; endproperty
   a_rst: assert property (p_rst) else $error("active at reset");
   property p_ctl;
      wr_take && S_AXI_AWADDR == 5'h00 |=>
         ##1 (!ANALOG_ON && !CORE_SAMPLE) [*2];
   endproperty
   a_ctl: assert property (p_ctl) else $error("control write kept run");
   property p_wr; wr_take |=> !S_AXI_AWREADY; endproperty
   a_wr: assert property (p_wr) else $error("write not answered");
   property p_pulse; CORE_SAMPLE |=> !CORE_SAMPLE; endproperty
   a_pulse: assert property (p_pulse) else $error("sample too long");
   property p_run; CORE_SAMPLE |-> ##[0:1] ANALOG_ON; endproperty
   a_run: assert property (p_run) else $error("sample while off");
endmodule

/* File: verification/sac_core_model.sv */
// Behavioural converter core: latches the level, counts conversion clocks
`timescale 1ns/1ps
module sac_core (
   input wire clk,
   input wire sample,
   input wire conv_clk,
   input wire analog_on,
   input wire [9:0] level,
   output wire [9:0] result,
   output reg done
);
   reg [9:0] held;
   reg [4:0] ticks;
   reg last;
   reg live;
   // Done after the 28th conversion clock rise of one sample
   always @(posedge clk) begin
      last <= conv_clk;
      live <= analog_on;
      done <= 1'b0;
      if (sample) begin
         held <= level;
         ticks <= 5'h00;
      end else if (analog_on && conv_clk && !last) begin
         ticks <= ticks + 5'h01;
         done <= ticks == 5'h1B;
      end
   end
   // Powered off the output floats, so from one cycle after power drops show the inverse, never a stale copy
   assign result = (analog_on || live) ? held : ~held;
endmodule

/* File: verification/tb_sac_control.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_sac_control;
   reg clk = 0, rst_n = 0, stop = 0, awv = 0, wv = 0, arv = 0, bry = 0;
   reg [4:0] a = 0;
   reg [31:0] wd = 0, q;
   reg [1:0] r;
   reg [18:0] rows [0:7] = '{19'h0B140, 19'h13140, 19'h2B100, 19'h33100,
      19'h402C5, 19'h502C5, 19'h6B100, 19'h7B100};
   integer errors = 0, tests_run = 0, cyc = 0, i, n;
   wire [31:0] rd;
   wire [9:0] res;
   wire [7:0] pins;
   wire [1:0] br, rr;
   wire dn, smp, cc, aon, irq, awr, wrr, arr, bv, rv;
   sac_control dut_u (.CLK(clk), .RST_N(rst_n), .STOP_MODE(stop),
      .CORE_RESULT(res), .CORE_DONE(dn), .CORE_SAMPLE(smp), .CHANNEL(),
      .CORE_CONV_CLK(cc), .ANALOG_ON(aon), .ANALOG_PIN_ENABLE(pins),
      .IRQ(irq), .S_AXI_AWADDR(a), .S_AXI_AWVALID(awv), .S_AXI_WDATA(wd),
      .S_AXI_AWREADY(awr), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wrr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(bry), .S_AXI_ARADDR(a), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(bry));
   sac_core core_u (.clk(clk), .sample(smp), .conv_clk(cc),
      .analog_on(aon), .level(10'h2C5), .result(res), .done(dn));
   initial forever #2 clk = ~clk;
   // Watchdog well above the fewer than two thousand cycles the sequence needs
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         errors = errors + 1;
         complete_run;
      end
   end
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         tests_run = tests_run + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
         end
      end
   endtask
   // One AXI transfer; ready is read mid-cycle, where it has settled
   task bus(input w, input [4:0] ad, input [31:0] d);
      reg ka, kw, kr, kd;
      begin
         @(posedge clk);
         a <= ad;
         wd <= d;
         awv <= w;
         wv <= w;
         arv <= !w;
         bry <= 1;
         kd = 0;
         while (!kd) begin
            @(negedge clk);
            {ka, kw, kr} = {awr, wrr, arr};
            kd = w ? bv : rv;
            q = rd;
            r = w ? br : rr;
            @(posedge clk);
            if (ka) awv <= 0;
            if (kw) wv <= 0;
            if (kr) arv <= 0;
         end
         bry <= 0;
      end
   endtask
   task complete_run;
      begin
         $display("errors %0d tests_run %0d", errors, tests_run);
         if (errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1;
      bus(0, 5'h00, 0);
      chk("ctl", 0, q);
      bus(1, 5'h00, 32'h05);
      bus(0, 5'h00, 0);
      chk("pd", 32'h05, q);
      bus(1, 5'h14, 32'hA5);
      chk("pins", 8'hA5, pins);
      bus(0, 5'h18, 0);
      chk("resp", 2'h2, r);
      bus(1, 5'h10, 1);
      // Format rows: mode bits against the expected result word
      for (i = 0; i < 8; i = i + 1) begin
         bus(1, 5'h00, {1'b1, rows[i][18:16], 4'h0});
         bus(1, 5'h04, 32'h43);
         while (irq !== 1'b1) @(negedge clk);
         bus(0, 5'h08, 0);
         chk("res", rows[i][15:0], q);
         bus(1, 5'h0C, 1);
         chk("irq", 0, irq);
      end
      bus(1, 5'h10, 0);
      bus(1, 5'h04, 32'h43);
      repeat (80) @(negedge clk);
      chk("mask", 0, irq);
      bus(1, 5'h10, 1);
      chk("unmask", 1, irq);
      bus(1, 5'h0C, 1);
      // Abort by control write, then a start while powered down
      for (n = 0; n < 2; n = n + 1) begin
         bus(1, 5'h00, n ? 32'h00 : 32'h80);
         bus(1, 5'h04, 32'h43);
         bus(1, 5'h00, n ? 32'h00 : 32'h80);
         repeat (80) @(negedge clk);
         chk("halt", 0, irq);
         chk("cclk", 0, cc);
      end
      bus(1, 5'h00, 32'h82);
      bus(1, 5'h04, 32'h43);
      while (cc !== 1'b1) @(negedge clk);
      for (n = 0; cc === 1'b1; n = n + 1) @(negedge clk);
      for (n = n; cc !== 1'b1; n = n + 1) @(negedge clk);
      chk("div", 6, n);
      @(posedge clk) stop <= 1;
      repeat (5) @(negedge clk);
      chk("stop", 0, aon);
      @(posedge clk) stop <= 0;
      repeat (300) @(negedge clk);
      chk("idle", 0, irq);
      bus(0, 5'h00, 0);
      chk("kept", 32'h82, q);
      bus(1, 5'h04, 32'h43);
      while (irq !== 1'b1) @(negedge clk);
      chk("wake", 1, irq);
      complete_run;
   end
endmodule
bind sac_control sac_chk chk_u (.CLK(CLK), .RST_N(RST_N),
   .STOP_MODE(STOP_MODE), .CORE_SAMPLE(CORE_SAMPLE), .ANALOG_ON(ANALOG_ON),
   .CORE_CONV_CLK(CORE_CONV_CLK), .S_AXI_AWADDR(S_AXI_AWADDR),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WVALID(S_AXI_WVALID));
